// file: ubc_cpu_model.sv
// cpu core and interrupt controller stand-in facing the break unit
`timescale 1ns/1ps
module ubc_cpu_model (
  // clock
  input  wire logic        clock_i,
  // request from the break unit
  input  wire logic        break_req_i,
  input  wire logic [1:0]  break_type_i,
  // instruction flow
  output logic             issue_valid_o,
  output logic             issue_accept_o,
  output logic [7:0]       issue_asid_o,
  output logic [1:0]       issue_addr_hit_o,
  output logic             retire_o,
  // branch capture
  output logic             branch_o,
  output logic [27:0]      branch_src_addr_o,
  output logic [2:0]       branch_pid_o,
  output logic [27:0]      branch_dst_addr_o
);
  int unsigned n_break = 0;
  logic [1:0]  last_type = 2'h0;
  initial begin
    issue_valid_o = 1'b0;
    issue_accept_o = 1'b0;
    issue_asid_o = 8'h00;
    issue_addr_hit_o = 2'h0;
    retire_o = 1'b0;
    branch_o = 1'b0;
    branch_src_addr_o = 28'h0;
    branch_pid_o = 3'h0;
    branch_dst_addr_o = 28'h0;
  end
  // a hit with valid low stands for an overrun fetch that never executes
  task automatic issue(input logic v, input logic acc, input logic [1:0] hit,
                       input logic [7:0] asid);
    @(posedge clock_i);
    issue_valid_o <= v;
    issue_accept_o <= acc;
    issue_addr_hit_o <= hit;
    issue_asid_o <= asid;
    @(posedge clock_i);
    issue_valid_o <= 1'b0;
    issue_addr_hit_o <= 2'h0;
    issue_asid_o <= ~asid;
  endtask : issue
  task automatic retire();
    @(posedge clock_i);
    retire_o <= 1'b1;
    @(posedge clock_i);
    retire_o <= 1'b0;
  endtask : retire
  // payload is scrambled once the pulse is over so stale values never match
  task automatic branch(input logic [27:0] src, input logic [2:0] pid,
                        input logic [27:0] dst);
    @(posedge clock_i);
    branch_o <= 1'b1;
    branch_src_addr_o <= src;
    branch_pid_o <= pid;
    branch_dst_addr_o <= dst;
    @(posedge clock_i);
    branch_o <= 1'b0;
    branch_src_addr_o <= ~src;
    branch_pid_o <= ~pid;
    branch_dst_addr_o <= ~dst;
  endtask : branch
  always @(posedge clock_i) begin
    if (break_req_i === 1'b1) begin
      n_break   <= n_break + 1;
      last_type <= break_type_i;
    end
  end
endmodule : ubc_cpu_model

// file: ubc_cycle_match.sv
// one channel's bus cycle condition compare
`timescale 1ns/1ps
module ubc_cycle_match (
  // channel setup
  input  wire logic [7:0] sel_i,
  input  wire logic [7:0] asid_cmp_i,
  // observed cycle
  input  wire logic       valid_i,
  input  wire logic       dma_i,
  input  wire logic       fetch_i,
  input  wire logic       write_i,
  input  wire logic [1:0] size_i,
  input  wire logic [7:0] asid_i,
  input  wire logic       addr_hit_i,
  input  wire logic       data_ok_i,
  // result
  output logic            hit_o
);
  logic [1:0] cd;
  logic [1:0] io;
  logic [1:0] rw;
  logic [1:0] sz;
  logic       on;
  logic       kind_ok;
  assign cd = sel_i[ubc_pkg::SEL_CD +: 2];
  assign io = sel_i[ubc_pkg::SEL_IO +: 2];
  assign rw = sel_i[ubc_pkg::SEL_RW +: 2];
  assign sz = sel_i[ubc_pkg::SEL_SZ +: 2];
  // a cd, io or rw group left at 00 disables the channel; sz at 00 matches any size
  assign on = (cd != ubc_pkg::SEL_OFF) && (io != ubc_pkg::SEL_OFF)
              && (rw != ubc_pkg::SEL_OFF);
  assign kind_ok = (dma_i ? cd[1] : cd[0]) && (fetch_i ? io[0] : io[1])
                   && (write_i ? rw[1] : rw[0])
                   && (sz == ubc_pkg::SZ_ANY || sz == size_i);
  assign hit_o = valid_i && on && kind_ok && (asid_i == asid_cmp_i)
                 && addr_hit_i && data_ok_i;
endmodule : ubc_cycle_match

// file: ubc_pkg.sv
// constants shared by the branch trace and fetch break logic
package ubc_pkg;
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 32;
  // register offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_BCS_A  = 8'h04;
  localparam logic [7:0] OFF_BCS_B  = 8'h08;
  localparam logic [7:0] OFF_ASID_A = 8'h0C;
  localparam logic [7:0] OFF_ASID_B = 8'h10;
  localparam logic [7:0] OFF_DCMP_B = 8'h14;
  localparam logic [7:0] OFF_DMSK_B = 8'h18;
  localparam logic [7:0] OFF_SRC    = 8'h1C;
  localparam logic [7:0] OFF_DST    = 8'h20;
  // break_control bit positions
  localparam int unsigned CB_A_CPU  = 15;
  localparam int unsigned CB_B_CPU  = 14;
  localparam int unsigned CB_A_DMA  = 13;
  localparam int unsigned CB_B_DMA  = 12;
  localparam int unsigned CB_TEN    = 11;
  localparam int unsigned CB_PCB_A  = 10;
  localparam int unsigned CB_DBE_B  = 7;
  localparam int unsigned CB_PCB_B  = 6;
  localparam int unsigned CB_TPTR   = 16;
  // trace word layout
  localparam int unsigned TV_BIT    = 31;
  localparam int unsigned TPID_LSB  = 28;
  localparam int unsigned TA_W      = 28;
  // bus cycle select fields, two bits each
  localparam int unsigned SEL_CD    = 6;
  localparam int unsigned SEL_IO    = 4;
  localparam int unsigned SEL_RW    = 2;
  localparam int unsigned SEL_SZ    = 0;
  localparam logic [1:0] SZ_ANY     = 2'h0;
  localparam logic [1:0] SZ_WORD    = 2'h2;
  localparam logic [1:0] SZ_LONG    = 2'h3;
  localparam logic [1:0] SEL_OFF    = 2'h0;
  localparam logic [15:0] HALF_MASK = 16'hFFFF;
  // break type towards the cpu
  localparam logic [1:0] BT_NONE    = 2'h0;
  localparam logic [1:0] BT_PRE     = 2'h1;
  localparam logic [1:0] BT_POST    = 2'h2;
  localparam logic [1:0] BT_DATA    = 2'h3;
endpackage : ubc_pkg

// file: ubc_trace_break.sv
// branch trace queue, space id compare and break request flow
// How it works
// - destination word is 32 bits, low 28 hold first fetch address after branch.
// - destination valid flag in bit 31 sets when a destination is captured.
// - reading the destination word clears its valid flag.
// - reset clears only the valid flags; stored addresses keep their values.
// - eight entries deep; every traced branch shifts entries up by one.
// - bits 30 to 28 of the destination word read zero; software writes zero.
// - two 8-bit space id compare registers, one per channel, read and write.
// - space id compare registers have no reset value.
// - a cd, io or rw bus cycle select group at 00 disables that channel; sz at 00 is any size.
// - satisfied condition raises a break request with its break type.
// - a match sets the channel's cpu or dma match flag by cycle kind.
// - match flags stay set until software writes zero to them.
// - near-simultaneous data and fetch breaks give one request; both flags may set.
// - cpu fetch read word/long selects fetch break; select bit picks pre or post.
// - pre break only on confirmed issued instructions, never on overrun fetches.
// - pre break hitting a delay slot is taken at the next acceptable point.
// - post break lets the instruction finish, then breaks before the next one.
// - post break on a delayed branch waits for the next acceptable point.
// - channel B fetch breaks ignore data compare and data mask.
// - tracing runs only while trace enable is 1; each branch pushes a pair.
// - one shared read pointer; it advances only after the destination read.
// - re-enabling trace invalidates the queue and restarts the trace pointer.
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module ubc_trace_break #(
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic                 clock_i,
  input  wire logic                 reset_i,
  // register port
  input  wire logic [7:0]           addr_i,
  input  wire logic [31:0]          wdata_i,
  input  wire logic                 write_i,
  input  wire logic                 read_i,
  output logic      [31:0]          rdata_o,
  // bus cycles seen on the data side
  input  wire logic                 cyc_valid_i,
  input  wire logic                 cyc_dma_i,
  input  wire logic                 cyc_write_i,
  input  wire logic [1:0]           cyc_size_i,
  input  wire logic [7:0]           cyc_asid_i,
  input  wire logic [31:0]          cyc_data_i,
  input  wire logic [1:0]           cyc_addr_hit_i,
  // instruction flow from the cpu
  input  wire logic                 issue_valid_i,
  input  wire logic                 issue_accept_i,
  input  wire logic [7:0]           issue_asid_i,
  input  wire logic [1:0]           issue_addr_hit_i,
  input  wire logic                 retire_i,
  // branch trace capture
  input  wire logic                 branch_i,
  input  wire logic [27:0]          branch_src_addr_i,
  input  wire logic [2:0]           branch_pid_i,
  input  wire logic [27:0]          branch_dst_addr_i,
  // break request
  output logic                      break_req_o,
  output logic      [1:0]           break_type_o
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam logic [PW-1:0] PTR_TOP = PW'(DEPTH - 1);
  localparam logic [PW-1:0] PTR_BOT = '0;

  logic [3:0]  flag_q;
  logic        trace_en_q;
  logic        pcb_a_q;
  logic        pcb_b_q;
  logic        dbe_b_q;
  logic [7:0]  bcs_a_q;
  logic [7:0]  bcs_b_q;
  logic [7:0]  asid_a_q;
  logic [7:0]  asid_b_q;
  logic [31:0] dcmp_q;
  logic [31:0] dmsk_q;

  logic [27:0] src_addr_q [DEPTH];
  logic [2:0]  pid_q      [DEPTH];
  logic [27:0] dst_addr_q [DEPTH];
  logic [DEPTH-1:0] svf_q;
  logic [DEPTH-1:0] dvf_q;
  logic [PW-1:0]    rd_ptr_q;
  logic [PW-1:0]    trace_ptr_q;

  logic pre_pend_q;
  logic post_arm_q;
  logic post_pend_q;
  logic data_pend_q;

  logic wr_ctrl;
  logic rd_src;
  logic rd_dst;
  logic push;
  logic reenable;
  assign wr_ctrl  = write_i && addr_i == ubc_pkg::OFF_CTRL;
  assign rd_src   = read_i && addr_i == ubc_pkg::OFF_SRC;
  assign rd_dst   = read_i && addr_i == ubc_pkg::OFF_DST;
  assign push     = trace_en_q && branch_i;
  assign reenable = wr_ctrl && wdata_i[ubc_pkg::CB_TEN] && !trace_en_q;

  // ---------------- configuration registers
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      trace_en_q <= 1'b0;
      pcb_a_q    <= 1'b0;
      pcb_b_q    <= 1'b0;
      dbe_b_q    <= 1'b0;
      bcs_a_q    <= 8'h00;
      bcs_b_q    <= 8'h00;
      dcmp_q     <= 32'h00000000;
      dmsk_q     <= 32'h00000000;
    end else if (write_i) begin
      unique case (addr_i)
        ubc_pkg::OFF_CTRL: begin
          trace_en_q <= wdata_i[ubc_pkg::CB_TEN];
          pcb_a_q    <= wdata_i[ubc_pkg::CB_PCB_A];
          pcb_b_q    <= wdata_i[ubc_pkg::CB_PCB_B];
          dbe_b_q    <= wdata_i[ubc_pkg::CB_DBE_B];
        end
        ubc_pkg::OFF_BCS_A:  bcs_a_q <= wdata_i[7:0];
        ubc_pkg::OFF_BCS_B:  bcs_b_q <= wdata_i[7:0];
        ubc_pkg::OFF_DCMP_B: dcmp_q  <= wdata_i;
        ubc_pkg::OFF_DMSK_B: dmsk_q  <= wdata_i;
        default: ;
      endcase
    end
  end

  // space id compares carry no reset so they stay undefined until written
  always_ff @(posedge clock_i) begin
    if (write_i && addr_i == ubc_pkg::OFF_ASID_A) begin
      asid_a_q <= wdata_i[7:0];
    end
    if (write_i && addr_i == ubc_pkg::OFF_ASID_B) begin
      asid_b_q <= wdata_i[7:0];
    end
  end

  // ---------------- condition compare
  logic data_ok_b;
  logic [31:0] dmiss;
  logic [1:0] hit_f;
  logic [1:0] hit_d;
  logic [1:0] fsz_a;
  logic [1:0] fsz_b;
  assign dmiss = (cyc_data_i ^ dcmp_q) & ~dmsk_q;
  assign data_ok_b = !dbe_b_q || (cyc_size_i == ubc_pkg::SZ_LONG ? dmiss == '0
                     : (dmiss[15:0] & ubc_pkg::HALF_MASK) == '0);
  // fetch compares present a word fetch when the channel asks for word
  assign fsz_a = bcs_a_q[ubc_pkg::SEL_SZ +: 2] == ubc_pkg::SZ_WORD ? ubc_pkg::SZ_WORD
                 : ubc_pkg::SZ_LONG;
  assign fsz_b = bcs_b_q[ubc_pkg::SEL_SZ +: 2] == ubc_pkg::SZ_WORD ? ubc_pkg::SZ_WORD
                 : ubc_pkg::SZ_LONG;

  // fetch side only sees issued instructions, so overrun fetches never count
  ubc_cycle_match u_fetch_a (
    .sel_i      (bcs_a_q),
    .asid_cmp_i (asid_a_q),
    .valid_i    (issue_valid_i),
    .dma_i      (1'b0),
    .fetch_i    (1'b1),
    .write_i    (1'b0),
    .size_i     (fsz_a),
    .asid_i     (issue_asid_i),
    .addr_hit_i (issue_addr_hit_i[0]),
    .data_ok_i  (1'b1),
    .hit_o      (hit_f[0])
  );
  ubc_cycle_match u_fetch_b (
    .sel_i      (bcs_b_q),
    .asid_cmp_i (asid_b_q),
    .valid_i    (issue_valid_i),
    .dma_i      (1'b0),
    .fetch_i    (1'b1),
    .write_i    (1'b0),
    .size_i     (fsz_b),
    .asid_i     (issue_asid_i),
    .addr_hit_i (issue_addr_hit_i[1]),
    .data_ok_i  (1'b1),
    .hit_o      (hit_f[1])
  );
  ubc_cycle_match u_data_a (
    .sel_i      (bcs_a_q),
    .asid_cmp_i (asid_a_q),
    .valid_i    (cyc_valid_i),
    .dma_i      (cyc_dma_i),
    .fetch_i    (1'b0),
    .write_i    (cyc_write_i),
    .size_i     (cyc_size_i),
    .asid_i     (cyc_asid_i),
    .addr_hit_i (cyc_addr_hit_i[0]),
    .data_ok_i  (1'b1),
    .hit_o      (hit_d[0])
  );
  ubc_cycle_match u_data_b (
    .sel_i      (bcs_b_q),
    .asid_cmp_i (asid_b_q),
    .valid_i    (cyc_valid_i),
    .dma_i      (cyc_dma_i),
    .fetch_i    (1'b0),
    .write_i    (cyc_write_i),
    .size_i     (cyc_size_i),
    .asid_i     (cyc_asid_i),
    .addr_hit_i (cyc_addr_hit_i[1]),
    .data_ok_i  (data_ok_b),
    .hit_o      (hit_d[1])
  );

  // ---------------- match flags: hardware sets, software writes 0 to clear
  logic [3:0] flag_set;
  assign flag_set = {hit_f[0] || (hit_d[0] && !cyc_dma_i),
                     hit_f[1] || (hit_d[1] && !cyc_dma_i),
                     hit_d[0] && cyc_dma_i,
                     hit_d[1] && cyc_dma_i};
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      flag_q <= 4'h0;
    end else begin
      // a new match wins over a clear in the same cycle
      flag_q <= (wr_ctrl ? (flag_q & wdata_i[ubc_pkg::CB_B_DMA +: 4]) : flag_q)
                | flag_set;
    end
  end

  // ---------------- break request flow
  logic pre_set;
  logic post_set;
  logic fire;
  assign pre_set  = (hit_f[0] && !pcb_a_q) || (hit_f[1] && !pcb_b_q);
  assign post_set = (hit_f[0] && pcb_a_q) || (hit_f[1] && pcb_b_q);
  // only an issue slot that can take a break carries one; delay slots pass by
  assign fire = issue_valid_i && issue_accept_i
                && (pre_set || pre_pend_q || post_pend_q || data_pend_q);

  always_ff @(posedge clock_i) begin
    if (reset_i || fire) begin
      // every pending source is consumed by the one request
      pre_pend_q  <= 1'b0;
      post_pend_q <= 1'b0;
      data_pend_q <= 1'b0;
    end else begin
      pre_pend_q  <= pre_pend_q || pre_set;
      post_pend_q <= post_pend_q || (post_arm_q && retire_i);
      data_pend_q <= data_pend_q || (|hit_d);
    end
  end

  // post break waits for the matched instruction to retire
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      post_arm_q <= 1'b0;
    end else if (post_set) begin
      post_arm_q <= 1'b1;
    end else if (retire_i) begin
      post_arm_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      break_req_o  <= 1'b0;
      break_type_o <= ubc_pkg::BT_NONE;
    end else begin
      break_req_o  <= fire;
      if (!fire) begin
        break_type_o <= ubc_pkg::BT_NONE;
      end else if (pre_set || pre_pend_q) begin
        break_type_o <= ubc_pkg::BT_PRE;
      end else if (post_pend_q) begin
        break_type_o <= ubc_pkg::BT_POST;
      end else begin
        break_type_o <= ubc_pkg::BT_DATA;
      end
    end
  end

  // ---------------- branch trace queue
  // payload has no reset: only the valid flags are defined after reset
  always_ff @(posedge clock_i) begin
    if (push) begin
      src_addr_q[0] <= branch_src_addr_i;
      pid_q[0]      <= branch_pid_i;
      dst_addr_q[0] <= branch_dst_addr_i;
      for (int i = 1; i < DEPTH; i++) begin
        src_addr_q[i] <= src_addr_q[i-1];
        pid_q[i]      <= pid_q[i-1];
        dst_addr_q[i] <= dst_addr_q[i-1];
      end
    end
  end

  logic [DEPTH-1:0] svf_d;
  logic [DEPTH-1:0] dvf_d;
  logic [PW:0]      clr_idx;
  always_comb begin
    svf_d = push ? {svf_q[DEPTH-2:0], 1'b1} : svf_q;
    dvf_d = push ? {dvf_q[DEPTH-2:0], 1'b1} : dvf_q;
    // the read entry moves up one place when a push lands in the same cycle
    clr_idx = {1'b0, rd_ptr_q} + (push ? (PW+1)'(1) : (PW+1)'(0));
    if (clr_idx < (PW+1)'(DEPTH)) begin
      if (rd_src) begin
        svf_d[clr_idx[PW-1:0]] = 1'b0;
      end
      if (rd_dst) begin
        dvf_d[clr_idx[PW-1:0]] = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i || reenable) begin
      svf_q <= '0;
      dvf_q <= '0;
    end else begin
      svf_q <= svf_d;
      dvf_q <= dvf_d;
    end
  end

  // shared read pointer survives a trace restart; an empty slot takes a push in place
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rd_ptr_q <= PTR_BOT;
    end else if (push && !rd_dst && dvf_q[rd_ptr_q] && rd_ptr_q != PTR_TOP) begin
      rd_ptr_q <= rd_ptr_q + PW'(1);
    end else if (rd_dst && !push && rd_ptr_q != PTR_BOT) begin
      rd_ptr_q <= rd_ptr_q - PW'(1);
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i || reenable) begin
      trace_ptr_q <= PTR_BOT;
    end else if (push && trace_ptr_q != PTR_TOP) begin
      trace_ptr_q <= trace_ptr_q + PW'(1);
    end
  end

  // ---------------- read data, valid only in the cycle after the strobe
  logic [31:0] rd_d;
  always_comb begin
    rd_d = 32'h00000000;
    unique case (addr_i)
      ubc_pkg::OFF_CTRL: begin
        rd_d[ubc_pkg::CB_B_DMA +: 4]  = flag_q;
        rd_d[ubc_pkg::CB_TEN]         = trace_en_q;
        rd_d[ubc_pkg::CB_PCB_A]       = pcb_a_q;
        rd_d[ubc_pkg::CB_PCB_B]       = pcb_b_q;
        rd_d[ubc_pkg::CB_DBE_B]       = dbe_b_q;
        rd_d[ubc_pkg::CB_TPTR +: PW]  = trace_ptr_q;
      end
      ubc_pkg::OFF_BCS_A:  rd_d[7:0] = bcs_a_q;
      ubc_pkg::OFF_BCS_B:  rd_d[7:0] = bcs_b_q;
      ubc_pkg::OFF_ASID_A: rd_d[7:0] = asid_a_q;
      ubc_pkg::OFF_ASID_B: rd_d[7:0] = asid_b_q;
      ubc_pkg::OFF_DCMP_B: rd_d = dcmp_q;
      ubc_pkg::OFF_DMSK_B: rd_d = dmsk_q;
      ubc_pkg::OFF_SRC: begin
        rd_d[ubc_pkg::TV_BIT]          = svf_q[rd_ptr_q];
        rd_d[ubc_pkg::TPID_LSB +: 3]   = pid_q[rd_ptr_q];
        rd_d[ubc_pkg::TA_W-1:0]        = src_addr_q[rd_ptr_q];
      end
      ubc_pkg::OFF_DST: begin
        rd_d[ubc_pkg::TV_BIT]          = dvf_q[rd_ptr_q];
        rd_d[ubc_pkg::TA_W-1:0]        = dst_addr_q[rd_ptr_q];
      end
      default: rd_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rdata_o <= 32'h00000000;
    end else begin
      rdata_o <= read_i ? rd_d : 32'h00000000;
    end
  end

  // ---------------- checks
  chk_dst_rsvd_zero: assert property (@(posedge clock_i) disable iff (reset_i)
    rd_dst |=> rdata_o[ubc_pkg::TV_BIT-1:ubc_pkg::TA_W] == 3'h0)
    else $error("reserved trace bits not zero");
  chk_push_sets_dvf: assert property (@(posedge clock_i) disable iff (reset_i)
    push && !reenable |=> dvf_q[0] && svf_q[0])
    else $error("push did not set valid flags");
  chk_dst_read_clr: assert property (@(posedge clock_i) disable iff (reset_i)
    rd_dst && !push |=> !dvf_q[$past(rd_ptr_q)])
    else $error("destination read left valid set");
  chk_reset_clr_vf: assert property (@(posedge clock_i)
    reset_i |=> dvf_q == '0 && svf_q == '0)
    else $error("reset did not clear valid flags");
  chk_flag_sticky: assert property (@(posedge clock_i) disable iff (reset_i)
    flag_q[3] && !wr_ctrl |=> flag_q[3])
    else $error("match flag dropped without a write");
  chk_sel_off_quiet: assert property (@(posedge clock_i) disable iff (reset_i)
    bcs_a_q[ubc_pkg::SEL_CD +: 2] == ubc_pkg::SEL_OFF |-> !hit_f[0] && !hit_d[0])
    else $error("disabled channel matched");
  chk_one_request: assert property (@(posedge clock_i) disable iff (reset_i)
    fire |=> !pre_pend_q && !post_pend_q && !data_pend_q)
    else $error("pending break survived a request");
  chk_pre_type: assert property (@(posedge clock_i) disable iff (reset_i)
    fire && pre_set |=> break_req_o && break_type_o == ubc_pkg::BT_PRE)
    else $error("pre break type wrong");
  chk_post_waits: assert property (@(posedge clock_i) disable iff (reset_i)
    post_set && !pre_set && !pre_pend_q && !post_pend_q && !data_pend_q |=> !break_req_o)
    else $error("post break before retire");
  chk_no_trace_off: assert property (@(posedge clock_i) disable iff (reset_i)
    !trace_en_q && !reenable |=> $stable(trace_ptr_q))
    else $error("trace moved while disabled");
endmodule : ubc_trace_break

// file: user_break_trace_and_fetch_break_tb_top.sv
// self-checking bench for the branch trace and fetch break unit
`timescale 1ns/1ps
module user_break_trace_and_fetch_break_tb_top;
  logic        clock_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic [31:0] rdata;
  logic        cv = 1'b0;
  logic        cdma = 1'b0;
  logic [7:0]  casid = 8'h00;
  logic [1:0]  chit = 2'h0;
  logic        brq;
  logic [1:0]  btyp;
  logic        iv, ia, rt, br;
  logic [7:0]  iasid;
  logic [1:0]  ihit;
  logic [27:0] bsrc, bdst;
  logic [2:0]  bpid;
  logic [31:0] d;
  int          errors = 0;
  int          n_compared = 0;
  int unsigned nb = 0;
  always #20 clock_i = ~clock_i;
  ubc_trace_break uut (
    .clock_i(clock_i), .reset_i(reset_i), .addr_i(addr), .wdata_i(wdata),
    .write_i(wr_s), .read_i(rd_s), .rdata_o(rdata), .cyc_valid_i(cv),
    .cyc_dma_i(cdma), .cyc_write_i(1'b0), .cyc_size_i(2'h3),
    .cyc_asid_i(casid), .cyc_data_i(32'h0), .cyc_addr_hit_i(chit),
    .issue_valid_i(iv), .issue_accept_i(ia), .issue_asid_i(iasid),
    .issue_addr_hit_i(ihit), .retire_i(rt), .branch_i(br),
    .branch_src_addr_i(bsrc), .branch_pid_i(bpid), .branch_dst_addr_i(bdst),
    .break_req_o(brq), .break_type_o(btyp));
  ubc_cpu_model cpu (
    .clock_i(clock_i), .break_req_i(brq), .break_type_i(btyp),
    .issue_valid_o(iv), .issue_accept_o(ia), .issue_asid_o(iasid),
    .issue_addr_hit_o(ihit), .retire_o(rt), .branch_o(br),
    .branch_src_addr_o(bsrc), .branch_pid_o(bpid), .branch_dst_addr_o(bdst));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock_i);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clock_i);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock_i);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask : rd
  // requests are counted by the partner; compare the count since last call
  task automatic brk(input int n, input logic [1:0] t);
    repeat (3) @(posedge clock_i);
    #1 chk(32'(cpu.n_break - nb), 32'(n));
    if (n > 0) chk({30'h0, cpu.last_type}, {30'h0, t});
    nb = cpu.n_break;
  endtask : brk
  task automatic t_regs();
    rd(ubc_pkg::OFF_CTRL);  chk(d, 32'h0);
    rd(ubc_pkg::OFF_DST);   chk({31'h0, d[31]}, 32'h0);
    wr(ubc_pkg::OFF_ASID_A, 32'h3C);
    wr(ubc_pkg::OFF_ASID_B, 32'h5A);
    rd(ubc_pkg::OFF_ASID_A); chk(d, 32'h3C);
    rd(ubc_pkg::OFF_ASID_B); chk(d, 32'h5A);
    rd(8'hFC);              chk(d, 32'h0);
  endtask : t_regs
  task automatic t_trace();
    cpu.branch(28'h0000100, 3'h2, 28'h0000200);
    rd(ubc_pkg::OFF_SRC);
    rd(ubc_pkg::OFF_DST); chk({31'h0, d[31]}, 32'h0);
    wr(ubc_pkg::OFF_CTRL, 32'h800);
    cpu.branch(28'h1234560, 3'h5, 28'hABCDEF1);
    rd(ubc_pkg::OFF_SRC);
    rd(ubc_pkg::OFF_DST); chk(d, {1'b1, 3'h0, 28'hABCDEF1});
    rd(ubc_pkg::OFF_DST); chk({31'h0, d[31]}, 32'h0);
    cpu.branch(28'h0000300, 3'h1, 28'h0000400);
    rd(ubc_pkg::OFF_CTRL); chk({31'h0, d[18:16] != 3'h0}, 32'h1);
    wr(ubc_pkg::OFF_CTRL, 32'h0);
    wr(ubc_pkg::OFF_CTRL, 32'h800);
    rd(ubc_pkg::OFF_SRC);
    rd(ubc_pkg::OFF_DST); chk({31'h0, d[31]}, 32'h0);
    rd(ubc_pkg::OFF_CTRL); chk({29'h0, d[18:16]}, 32'h0);
    // two pushes: the older pair is read first
    cpu.branch(28'h0000500, 3'h3, 28'h0000600);
    cpu.branch(28'h0000700, 3'h4, 28'h0000800);
    rd(ubc_pkg::OFF_SRC); chk(d, {1'b1, 3'h3, 28'h0000500});
    rd(ubc_pkg::OFF_DST); chk(d, {1'b1, 3'h0, 28'h0000600});
    rd(ubc_pkg::OFF_SRC); chk(d, {1'b1, 3'h4, 28'h0000700});
    rd(ubc_pkg::OFF_DST); chk(d, {1'b1, 3'h0, 28'h0000800});
  endtask : t_trace
  task automatic t_pre();
    wr(ubc_pkg::OFF_BCS_A, 32'h56);
    wr(ubc_pkg::OFF_CTRL, 32'h0);
    cpu.issue(1'b1, 1'b1, 2'h1, 8'h3D);
    brk(0, ubc_pkg::BT_NONE);
    cpu.issue(1'b1, 1'b1, 2'h1, 8'h3C);
    brk(1, ubc_pkg::BT_PRE);
    rd(ubc_pkg::OFF_CTRL); chk({31'h0, d[15]}, 32'h1);
    wr(ubc_pkg::OFF_CTRL, 32'h0);
    rd(ubc_pkg::OFF_CTRL); chk({31'h0, d[15]}, 32'h0);
  endtask : t_pre
  task automatic t_block();
    cpu.issue(1'b0, 1'b1, 2'h1, 8'h3C);
    brk(0, ubc_pkg::BT_NONE);
    wr(ubc_pkg::OFF_BCS_A, 32'h16);
    cpu.issue(1'b1, 1'b1, 2'h1, 8'h3C);
    brk(0, ubc_pkg::BT_NONE);
    wr(ubc_pkg::OFF_BCS_A, 32'h56);
    cpu.issue(1'b1, 1'b0, 2'h1, 8'h3C);
    brk(0, ubc_pkg::BT_NONE);
    cpu.issue(1'b1, 1'b1, 2'h0, 8'h00);
    brk(1, ubc_pkg::BT_PRE);
  endtask : t_block
  task automatic t_post();
    wr(ubc_pkg::OFF_CTRL, 32'h400);
    cpu.issue(1'b1, 1'b1, 2'h1, 8'h3C);
    brk(0, ubc_pkg::BT_NONE);
    cpu.retire();
    cpu.issue(1'b1, 1'b0, 2'h0, 8'h00);
    brk(0, ubc_pkg::BT_NONE);
    cpu.issue(1'b1, 1'b1, 2'h0, 8'h00);
    brk(1, ubc_pkg::BT_POST);
  endtask : t_post
  // a data hit on B and a pre fetch hit on A close together
  task automatic t_merge();
    wr(ubc_pkg::OFF_CTRL, 32'h0);
    wr(ubc_pkg::OFF_BCS_B, 32'h64);
    @(posedge clock_i);
    cv <= 1'b1;
    casid <= 8'h5A;
    chit <= 2'h2;
    cpu.issue(1'b1, 1'b1, 2'h1, 8'h3C);
    cv <= 1'b0;
    chit <= 2'h0;
    brk(1, ubc_pkg::BT_PRE);
    rd(ubc_pkg::OFF_CTRL); chk({30'h0, d[15:14]}, 32'h3);
    @(posedge clock_i);
    cv <= 1'b1;
    chit <= 2'h2;
    @(posedge clock_i);
    cv <= 1'b0;
    chit <= 2'h0;
    cpu.issue(1'b1, 1'b1, 2'h0, 8'h00);
    brk(1, ubc_pkg::BT_DATA);
  endtask : t_merge
  // dma hit on B, then B data compare on a data cycle and on a fetch
  task automatic t_chan_b();
    wr(ubc_pkg::OFF_CTRL, 32'h0);
    wr(ubc_pkg::OFF_BCS_B, 32'hA4);
    @(posedge clock_i);
    cv <= 1'b1;
    cdma <= 1'b1;
    chit <= 2'h2;
    @(posedge clock_i);
    cv <= 1'b0;
    cdma <= 1'b0;
    chit <= 2'h0;
    cpu.issue(1'b1, 1'b1, 2'h0, 8'h00);
    brk(1, ubc_pkg::BT_DATA);
    rd(ubc_pkg::OFF_CTRL); chk({28'h0, d[15:12]}, 32'h1);
    wr(ubc_pkg::OFF_DCMP_B, 32'h55);
    wr(ubc_pkg::OFF_CTRL, 32'h80);
    wr(ubc_pkg::OFF_BCS_B, 32'h64);
    @(posedge clock_i);
    cv <= 1'b1;
    chit <= 2'h2;
    @(posedge clock_i);
    cv <= 1'b0;
    chit <= 2'h0;
    cpu.issue(1'b1, 1'b1, 2'h0, 8'h00);
    brk(0, ubc_pkg::BT_NONE);
    wr(ubc_pkg::OFF_BCS_B, 32'h54);
    cpu.issue(1'b1, 1'b1, 2'h2, 8'h5A);
    brk(1, ubc_pkg::BT_PRE);
  endtask : t_chan_b
  task automatic stop_test();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (4) @(posedge clock_i);
    reset_i <= 1'b0;
    t_regs();
    t_trace();
    t_pre();
    t_block();
    t_post();
    t_merge();
    t_chan_b();
    stop_test();
  end
  // the whole run needs under two hundred cycles
  initial begin
    #80000;
    errors++;
    stop_test();
  end
endmodule : user_break_trace_and_fetch_break_tb_top
